// >>> shared/eeprom_host_pkg.sv
// What this block does
// [R1] device drives stored byte when chip select and output enable low, strobe high
// [R2] device floats data pins when chip select or output enable high; the model drives the inverse of its last value instead
// [R3] write starts on strobe low pulse with chip select low, output enable high
// [R4] device latches address on the later falling edge of select or strobe
// [R5] device latches data on the first rising edge of select or strobe
// [R6] programming self-timed; reads during write cycle are status polls
// [R7] one to 256 bytes programmed together in one period
// [R8] host loads next page byte within 150 us, else programming starts
// [R9] host keeps page select bits constant across a page load
// [R10] byte-in-page bits pick the byte; any order, reload replaces earlier value
// [R11] only loaded bytes are programmed
// [R12] during write, poll of last byte returns inverted bit 7
// [R13] during write, toggle status bit inverts on every read
// [R14] no write while output enable low, select high or strobe high
// [R15] select or strobe pulses under about 15 ns start no write
// [R16] writes inhibited below 3.8 V and for 5 ms after power reaches it
// [R17] three-byte sequence enables protection after the write cycle time
// [R18] protected writes need the three-byte prefix before the data
// [R19] protection state is nonvolatile, shipped disabled
// [R20] command sequences follow page-load timing; command bytes not programmed
// [R21] unprefixed protected write runs the timer but programs nothing
// [R22] identification area at 7ff80 to 7ffff readable and writable with id select high
package eeprom_host_pkg;
	localparam int ADDR_W        = 19;
	localparam int DATA_W        = 8;
	localparam int PAGE_LSB      = 8;
	localparam int CLK_MHZ       = 50;
	localparam int CLK_NS        = 20;
	// strobe timing, least times round up
	localparam int WP_NS         = 100;
	localparam int WPH_NS        = 50;
	localparam int AH_NS         = 50;
	localparam int ACC_NS        = 200;
	localparam int WP_CYC        = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC       = (WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC       = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
	// byte-load window, longest time rounds down
	localparam int BLC_US        = 150;
	localparam int BLC_CYC       = BLC_US * CLK_MHZ;
	// write cycle time and power-on lockout
	localparam int WC_MS         = 10;
	localparam int WC_CYC        = WC_MS * 1000 * CLK_MHZ;
	localparam int PWRUP_MS      = 5;
	localparam int PWRUP_CYC     = PWRUP_MS * 1000 * CLK_MHZ;
	localparam int TMR_W         = 20;
	// protection command sequence
	localparam logic [ADDR_W-1:0] CMD_ADDR0 = 19'h05555;
	localparam logic [ADDR_W-1:0] CMD_ADDR1 = 19'h02aaa;
	localparam logic [ADDR_W-1:0] CMD_ADDR2 = 19'h05555;
	localparam logic [DATA_W-1:0] CMD_DATA0 = 8'haa;
	localparam logic [DATA_W-1:0] CMD_DATA1 = 8'h55;
	localparam logic [DATA_W-1:0] CMD_EN    = 8'ha0;
	localparam logic [DATA_W-1:0] CMD_DIS   = 8'h80;
	localparam logic [DATA_W-1:0] CMD_DIS3  = 8'haa;
	localparam logic [DATA_W-1:0] CMD_DIS4  = 8'h55;
	localparam logic [DATA_W-1:0] CMD_DIS5  = 8'h20;
	localparam logic [ADDR_W-1:0] ID_BASE   = 19'h7ff80;
	localparam int POLL_BIT      = 7;
	localparam int TOGGLE_BIT    = 6;
	localparam int BCNT_W        = 9;

	typedef enum logic [2:0] {
		OP_READ    = 3'h0,
		OP_WRITE   = 3'h1,
		OP_SDP_ON  = 3'h2,
		OP_SDP_OFF = 3'h3
	} op_e;

	typedef struct packed {
		op_e               op;
		logic              protect;
		logic              id_area;
		logic              last;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} host_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              id_hv;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} mem_pins_s;
endpackage : eeprom_host_pkg

// >>> verif/eeprom_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev_model
	import eeprom_host_pkg::*;
#(
	parameter int BLC_NS = 1280,
	parameter int WC_NS  = 2000,
	parameter int ACC_NS = 150
)
(
	input  wire eeprom_host_pkg::mem_pins_s         pins_i,
	output wire logic [eeprom_host_pkg::DATA_W-1:0] dq_o
);
	logic [7:0]  mem [logic [18:0]];
	logic [26:0] q [$];
	logic [26:0] e [$];
	logic [18:0] a_q;
	logic [7:0]  last_d = 8'h00;
	logic [7:0]  drv = 8'h00;
	logic        busy = 1'b0;
	logic        tog = 1'b0;
	logic        prot = 1'b0;
	logic        wr_act = 1'b0;
	logic        rd_seen = 1'b0;
	logic        pn;
	int          s;
	realtime     t0;
	realtime     t_last = 0.0;
	function automatic logic [7:0] rd(input logic [18:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction : rd
	// released bus shows the inverse of the last value, never a stale copy
	assign #(ACC_NS) dq_o = (!pins_i.ce_n && !pins_i.oe_n && pins_i.we_n) ? drv : ~drv;
	always @*
		if (!pins_i.ce_n && !pins_i.oe_n)
			drv = busy ? {~last_d[7], tog, last_d[5:0]} : rd(pins_i.addr);
	always @(negedge pins_i.oe_n)
	begin
		if (busy && !pins_i.ce_n)
			tog = ~tog;
		if (q.size() != 0)
			rd_seen = 1'b1;
	end
	always @(negedge pins_i.we_n or negedge pins_i.ce_n)
		if (!pins_i.we_n && !pins_i.ce_n && pins_i.oe_n)
		begin
			a_q = pins_i.addr;
			wr_act = 1'b1;
			t0 = $realtime;
		end
	always @(posedge pins_i.we_n or posedge pins_i.ce_n)
		if (wr_act)
		begin
			wr_act = 1'b0;
			if (!busy && $realtime - t0 >= 15.0)
			begin
				q.push_back({a_q, pins_i.dq_oe ? pins_i.dq_out : dq_o});
				t_last = $realtime;
			end
		end
	initial forever
	begin
		while (q.size() == 0 || ($realtime - t_last < BLC_NS && !rd_seen))
			#10;
		e = q;
		q.delete();
		rd_seen = 1'b0;
		busy = 1'b1;
		pn = prot;
		s = 0;
		last_d = e[$][7:0];
		if (e.size() >= 3 && e[0] == {CMD_ADDR0, CMD_DATA0} && e[1] == {CMD_ADDR1, CMD_DATA1}
			&& e[2][26:8] == CMD_ADDR2 && (e[2][7:0] == CMD_EN || e[2][7:0] == CMD_DIS))
		begin
			pn = (e[2][7:0] == CMD_EN);
			s = 3;
		end
		#(WC_NS);
		if (s == 3 || !prot)
			for (int i = s; i < e.size(); i++)
				mem[e[i][26:8]] = e[i][7:0];
		prot = pn;
		busy = 1'b0;
	end
endmodule : eeprom_dev_model
`default_nettype wire

// >>> verif/eeprom_host_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_ctrl_monitor
	import eeprom_host_pkg::*;
#(
	parameter int unsigned PWRUP_CYCLES = 16
)
(
	input  wire logic                       clk_sys_i,
	input  wire logic                       rstn_i,
	input  wire logic                       req_valid_i,
	input  wire eeprom_host_pkg::host_req_s req_i,
	input  wire logic                       req_ready_o,
	input  wire logic                       rd_valid_o,
	input  wire logic [7:0]                 rd_data_o,
	input  wire logic                       wr_done_o,
	input  wire logic                       wr_timeout_o,
	input  wire eeprom_host_pkg::mem_pins_s pins_o,
	input  wire logic [7:0]                 dq_i
);
	int unsigned up_q;
	wire logic   take = req_valid_i && req_ready_o;
	// counts edges since reset so early acceptance is caught
	always_ff @(posedge clk_sys_i or negedge rstn_i)
		if (!rstn_i)
			up_q <= 0;
		else if (up_q < PWRUP_CYCLES)
			up_q <= up_q + 1;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	chk_bus_no_fight: assert property (pins_o.dq_oe |-> pins_o.oe_n)
		else $error("host drives data while output enable low");
	chk_write_enables: assert property (!pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n)
		else $error("strobe low without select low and output enable high");
	chk_strobe_width: assert property ($fell(pins_o.we_n) |-> !pins_o.we_n [*5])
		else $error("write strobe low pulse too short");
	chk_strobe_high: assert property ($rose(pins_o.we_n) |-> pins_o.we_n [*3])
		else $error("write strobe high time too short");
	chk_addr_data_hold: assert property (!pins_o.we_n |-> $stable(pins_o.addr) && $stable(pins_o.dq_out))
		else $error("address or data moved while strobe low");
	chk_data_driven: assert property (!pins_o.we_n |-> pins_o.dq_oe)
		else $error("data not driven during strobe");
	chk_read_timing: assert property (take && req_i.op == OP_READ |=> (!pins_o.ce_n && !pins_o.oe_n && pins_o.we_n) ##12 rd_valid_o)
		else $error("read cycle shape or latency wrong");
	chk_busy_refuse: assert property (take |=> !req_ready_o)
		else $error("ready stayed high after a request was taken");
	chk_power_lockout: assert property (req_ready_o |-> up_q >= PWRUP_CYCLES)
		else $error("request accepted inside power-up lockout");
endmodule : eeprom_host_ctrl_monitor
`default_nettype wire

// >>> verif/eeprom_host_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_ctrl_test;
	import eeprom_host_pkg::*;
	localparam int unsigned PWRUP = 16;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        req_valid_i = 1'b0;
	host_req_s   req_i = '0;
	logic        req_ready_o, rd_valid_o, wr_done_o, wr_timeout_o, tmo;
	logic [7:0]  rd_data_o;
	logic        idsel = 1'b0;
	wire logic [7:0] dq_i;
	mem_pins_s   pins_o;
	int          n_errors = 0;
	int          n_checks = 0;
	eeprom_host_ctrl #(.BLC_CYCLES(64), .WC_CYCLES(200), .PWRUP_CYCLES(PWRUP)) i_eeprom_host_ctrl (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.wr_done_o(wr_done_o), .wr_timeout_o(wr_timeout_o), .pins_o(pins_o), .dq_i(dq_i));
	eeprom_dev_model #(.BLC_NS(1280), .WC_NS(2000), .ACC_NS(150)) i_eeprom_dev_model (
		.pins_i(pins_o), .dq_o(dq_i));
	always #10 clk_sys_i = ~clk_sys_i;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1
	// request held until the edge that samples ready high
	task automatic send(input op_e op, input logic [18:0] a, input logic [7:0] d,
		input logic p, input logic l);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		req_i <= '{op: op, protect: p, id_area: idsel, last: l, addr: a, data: d};
		req_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		while (req_ready_o !== 1'b1 && k < 1000)
		begin
			@(posedge clk_sys_i);
			k++;
		end
		chk1(req_ready_o, 1'b1);
		req_valid_i <= 1'b0;
	endtask : send
	task automatic wait_done();
		int k;
		k = 0;
		tmo = 1'b0;
		while (wr_done_o !== 1'b1 && k < 3000)
		begin
			@(posedge clk_sys_i);
			k++;
			if (wr_timeout_o === 1'b1)
				tmo = 1'b1;
		end
		chk1(wr_done_o, 1'b1);
	endtask : wait_done
	task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp);
		int k;
		k = 0;
		send(OP_READ, a, 8'h00, 1'b0, 1'b0);
		while (rd_valid_o !== 1'b1 && k < 100)
		begin
			@(posedge clk_sys_i);
			k++;
		end
		chk1(rd_valid_o, 1'b1);
		chk8(rd_data_o, exp);
	endtask : rd_chk
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_byte();
		send(OP_WRITE, 19'h00123, 8'h3c, 1'b0, 1'b1);
		wait_done();
		chk1(tmo, 1'b0);
		rd_chk(19'h00123, 8'h3c);
	endtask : t_byte
	task automatic t_ident();
		idsel = 1'b1;
		send(OP_WRITE, ID_BASE, 8'h5a, 1'b0, 1'b1);
		@(posedge clk_sys_i);
		chk1(pins_o.id_hv, 1'b1);
		wait_done();
		rd_chk(ID_BASE, 8'h5a);
		idsel = 1'b0;
	endtask : t_ident
	task automatic t_page();
		send(OP_WRITE, 19'h00105, 8'h11, 1'b0, 1'b0);
		send(OP_WRITE, 19'h00101, 8'h22, 1'b0, 1'b0);
		send(OP_WRITE, 19'h00105, 8'h33, 1'b0, 1'b0);
		send(OP_WRITE, 19'h001ff, 8'h44, 1'b0, 1'b1);
		wait_done();
		rd_chk(19'h00105, 8'h33);
		rd_chk(19'h00101, 8'h22);
		rd_chk(19'h001ff, 8'h44);
		rd_chk(19'h00102, 8'hff);
	endtask : t_page
	task automatic t_window();
		send(OP_WRITE, 19'h00200, 8'h5a, 1'b0, 1'b0);
		wait_done();
		chk1(tmo, 1'b1);
		rd_chk(19'h00200, 8'h5a);
	endtask : t_window
	task automatic t_protect();
		send(OP_SDP_ON, CMD_ADDR0, CMD_EN, 1'b0, 1'b1);
		wait_done();
		send(OP_WRITE, 19'h00300, 8'h77, 1'b0, 1'b1);
		wait_done();
		rd_chk(19'h00300, 8'hff);
		send(OP_WRITE, 19'h00300, 8'h66, 1'b1, 1'b1);
		wait_done();
		rd_chk(19'h00300, 8'h66);
		rd_chk(CMD_ADDR1, 8'hff);
		send(OP_SDP_OFF, CMD_ADDR0, CMD_DIS, 1'b0, 1'b1);
		wait_done();
		send(OP_WRITE, 19'h00301, 8'h99, 1'b0, 1'b1);
		wait_done();
		rd_chk(19'h00301, 8'h99);
	endtask : t_protect
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		int n;
		n = 0;
		repeat (8) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		while (req_ready_o !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		chk1(n >= PWRUP && n < 100, 1'b1);
		t_byte();
		t_page();
		t_window();
		t_protect();
		t_ident();
		end_of_test();
	end
	initial
	begin
		#800000;
		n_errors++;
		end_of_test();
	end
endmodule : eeprom_host_ctrl_test
bind eeprom_host_ctrl eeprom_host_ctrl_monitor #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_eeprom_host_ctrl_monitor (
	.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
	.req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
	.wr_done_o(wr_done_o), .wr_timeout_o(wr_timeout_o), .pins_o(pins_o), .dq_i(dq_i));
`default_nettype wire

// >>> verilog/eeprom_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_ctrl
#(
	parameter int unsigned BLC_CYCLES   = eeprom_host_pkg::BLC_CYC,
	parameter int unsigned WC_CYCLES    = eeprom_host_pkg::WC_CYC,
	parameter int unsigned PWRUP_CYCLES = eeprom_host_pkg::PWRUP_CYC
)
(
	input  wire logic                                  clk_sys_i,
	input  wire logic                                  rstn_i,
	input  wire logic                                  req_valid_i,
	input  wire eeprom_host_pkg::host_req_s            req_i,
	output logic                                       req_ready_o,
	output logic                                       rd_valid_o,
	output logic [eeprom_host_pkg::DATA_W-1:0]         rd_data_o,
	output logic                                       wr_done_o,
	output logic                                       wr_timeout_o,
	output eeprom_host_pkg::mem_pins_s                 pins_o,
	input  wire logic [eeprom_host_pkg::DATA_W-1:0]    dq_i
);
	import eeprom_host_pkg::*;

	// ------------------------------------------------------------
	// reset and input synchronisers
	// ------------------------------------------------------------
	logic                rst_s1_q;
	logic                rstn_q;
	logic [DATA_W-1:0]   dq_s1_q;
	logic [DATA_W-1:0]   dq_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_s1_q <= 1'b0;
			rstn_q   <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rstn_q   <= rst_s1_q;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			dq_s1_q <= 8'h00;
			dq_q    <= 8'h00;
		end
		else
		begin
			dq_s1_q <= dq_i;
			dq_q    <= dq_s1_q;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		S_PWRUP = 8'h01,
		S_IDLE  = 8'h02,
		S_RD    = 8'h04,
		S_WLOW  = 8'h08,
		S_WHIGH = 8'h10,
		S_LOAD  = 8'h20,
		S_POLL  = 8'h40,
		S_PREP  = 8'h80
	} state_e;

	state_e              state_q;
	logic [TMR_W+2:0]    tmr_q;
	logic [TMR_W+2:0]    wc_q;
	logic [1:0]          pre_q;
	logic                pre_active_q;
	logic                last_q;
	logic                poll_prev_q;
	logic                poll_first_q;
	logic [ADDR_W-1:0]   page_q;
	logic [ADDR_W-1:0]   last_addr_q;
	logic [DATA_W-1:0]   last_data_q;
	host_req_s           cur_q;
	logic [ADDR_W-1:0]   pre_addr;
	logic [DATA_W-1:0]   pre_data;

	// protection prefix or disable sequence bytes, issued before the payload
	assign pre_addr = (pre_q == 2'd1) ? CMD_ADDR1 : ((pre_q == 2'd0) ? CMD_ADDR0 : CMD_ADDR2);
	assign pre_data = (pre_q == 2'd0) ? CMD_DATA0 :
	                  (pre_q == 2'd1) ? CMD_DATA1 :
	                  (cur_q.op == OP_SDP_OFF) ? CMD_DIS : CMD_EN;

	always_ff @(posedge clk_sys_i or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			state_q      <= S_PWRUP;
			tmr_q        <= '0;
			wc_q         <= '0;
			pre_q        <= 2'd0;
			pre_active_q <= 1'b0;
			last_q       <= 1'b0;
			poll_prev_q  <= 1'b0;
			poll_first_q <= 1'b0;
			page_q       <= '0;
			last_addr_q  <= '0;
			last_data_q  <= 8'h00;
			cur_q        <= '0;
			req_ready_o  <= 1'b0;
			rd_valid_o   <= 1'b0;
			rd_data_o    <= 8'h00;
			wr_done_o    <= 1'b0;
			wr_timeout_o <= 1'b0;
			pins_o       <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
			                  id_hv: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
		end
		else
		begin
			rd_valid_o   <= 1'b0;
			wr_done_o    <= 1'b0;
			wr_timeout_o <= 1'b0;
			case (state_q)
				S_PWRUP:
				begin
					// no writes until the device power-on lockout has passed
					tmr_q <= tmr_q + 1'b1; // R16
					if (tmr_q >= (TMR_W+3)'(PWRUP_CYCLES))
					begin
						state_q     <= S_IDLE;
						req_ready_o <= 1'b1;
					end
				end
				S_IDLE:
				begin
					if (req_valid_i)
					begin
						cur_q        <= req_i;
						req_ready_o  <= 1'b0;
						tmr_q        <= '0;
						pins_o.addr  <= req_i.addr;
						pins_o.id_hv <= req_i.id_area; // R22
						if (req_i.op == OP_READ)
						begin
							// R1, R2: select and output enable low, strobe high
							pins_o.ce_n <= 1'b0;
							pins_o.oe_n <= 1'b0;
							state_q     <= S_RD;
						end
						else
						begin
							pre_active_q <= req_i.protect || req_i.op != OP_WRITE; // R18
							pre_q        <= 2'd0;
							state_q      <= S_PREP;
						end
					end
				end
				S_RD:
				begin
					tmr_q <= tmr_q + 1'b1;
					if (tmr_q == (TMR_W+3)'(ACC_CYC))
					begin
						pins_o.ce_n <= 1'b1; // R2
						pins_o.oe_n <= 1'b1;
						pins_o.id_hv <= 1'b0;
						rd_data_o   <= dq_q;
						rd_valid_o  <= 1'b1;
						req_ready_o <= 1'b1;
						state_q     <= S_IDLE;
					end
				end
				S_PREP:
				begin
					// output enable high first, then a strobe of at least 100 ns
					pins_o.oe_n   <= 1'b1; // R14
					pins_o.ce_n   <= 1'b0;
					pins_o.dq_oe  <= 1'b1;
					pins_o.addr   <= pre_active_q ? pre_addr : cur_q.addr;
					pins_o.dq_out <= pre_active_q ? pre_data : cur_q.data;
					tmr_q         <= '0;
					state_q       <= S_WLOW;
				end
				S_WLOW:
				begin
					pins_o.we_n <= 1'b0; // R3
					tmr_q       <= tmr_q + 1'b1;
					// wide pulse keeps clear of the device noise filter
					if (tmr_q == (TMR_W+3)'(WP_CYC))
					begin
						pins_o.we_n <= 1'b1; // R5 R15
						tmr_q       <= '0;
						state_q     <= S_WHIGH;
					end
				end
				S_WHIGH:
				begin
					// address held through the rising edge for the hold time
					tmr_q <= tmr_q + 1'b1; // R4
					if (tmr_q == (TMR_W+3)'(WPH_CYC))
					begin
						tmr_q <= '0;
						if (pre_active_q && pre_q != 2'd2)
						begin
							pre_q   <= pre_q + 2'd1; // R17
							state_q <= S_PREP;
						end
						else if (pre_active_q && cur_q.op == OP_WRITE)
						begin
							pre_active_q <= 1'b0; // R18 R20
							state_q      <= S_PREP;
						end
						else if (pre_active_q && cur_q.op != OP_WRITE)
						begin
							pre_active_q <= 1'b0;
							pins_o.ce_n  <= 1'b1;
							pins_o.dq_oe <= 1'b0;
							poll_first_q <= 1'b1;
							wc_q         <= '0;
							last_addr_q  <= CMD_ADDR2;
							last_data_q  <= 8'h00;
							// command bytes are not programmed; wait out the cycle
							state_q      <= S_POLL; // R20
						end
						else
						begin
							pre_active_q <= 1'b0;
							page_q       <= cur_q.addr;
							last_addr_q  <= pins_o.addr;
							last_data_q  <= pins_o.dq_out;
							last_q       <= cur_q.last;
							req_ready_o  <= !cur_q.last;
							state_q      <= S_LOAD;
						end
					end
				end
				S_LOAD:
				begin
					tmr_q <= tmr_q + 1'b1;
					// next byte of the same page, before the load window closes
					if (!last_q && req_valid_i && req_i.op == OP_WRITE &&
					    req_i.addr[ADDR_W-1:PAGE_LSB] == page_q[ADDR_W-1:PAGE_LSB] &&
					    tmr_q < (TMR_W+3)'(BLC_CYCLES - 8)) // R8 R9 R10
					begin
						cur_q        <= req_i;
						req_ready_o  <= 1'b0;
						pre_active_q <= 1'b0;
						state_q      <= S_PREP;
					end
					else if (last_q || tmr_q >= (TMR_W+3)'(BLC_CYCLES - 8))
					begin
						// R7 R11: only loaded bytes went to the device
						req_ready_o  <= 1'b0;
						pins_o.ce_n  <= 1'b1;
						pins_o.dq_oe <= 1'b0;
						wr_timeout_o <= !last_q;
						poll_first_q <= 1'b1;
						wc_q         <= '0;
						tmr_q        <= '0;
						state_q      <= S_POLL;
					end
				end
				S_POLL:
				begin
					// reads act as status polls until the device finishes
					wc_q        <= wc_q + 1'b1; // R6 R21
					tmr_q       <= tmr_q + 1'b1;
					pins_o.addr <= last_addr_q;
					pins_o.ce_n <= 1'b0;
					pins_o.oe_n <= 1'b0;
					if (tmr_q == (TMR_W+3)'(ACC_CYC))
					begin
						pins_o.ce_n  <= 1'b1;
						pins_o.oe_n  <= 1'b1;
						tmr_q        <= '0;
						poll_prev_q  <= dq_q[TOGGLE_BIT];
						poll_first_q <= 1'b0;
						// done once toggling stops and bit 7 shows true data, or once wc_q reaches WC_CYCLES
						if ((!poll_first_q && dq_q[TOGGLE_BIT] == poll_prev_q &&
						     dq_q[POLL_BIT] == last_data_q[POLL_BIT]) ||
						    wc_q >= (TMR_W+3)'(WC_CYCLES)) // R12 R13
						begin
							pins_o.id_hv <= 1'b0;
							wr_done_o    <= 1'b1;
							req_ready_o  <= 1'b1;
							state_q      <= S_IDLE;
						end
					end
				end
				default:
				begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule : eeprom_host_ctrl
`default_nettype wire
